// [rtl/ifcnt_top.sv]
// Gated 16-bit intermediate-frequency counter with pin routing
// Contract
// R1: Timed gate opens at next 1 kHz tick after start, lasts 1/4/8 ms.
// R2: Selected input counted in 16-bit up-counter while gate open.
// R3: Gate status flag cleared when gate closes.
// R4: Gate status flag set as soon as start is written.
// R5: Open gate setting opens gate immediately without start.
// R6: Software must not start while open gate selected.
// R7: Count clear works in every gate setting.
// R8: Leaving open setting closes gate; restoring it reopens.
// R9: Result read at address 43H, 16 bits; writes ignored.
// R10: FM mode counts shared pin after divide-by-two.
// R11: AM mode counts selected pin directly.
// R12: Software waits for amplifier settling before starting.
// R13: Software polls status and reads only after gate closed.
// R14: Gate interval derived by dividing the 75 kHz clock.
// R15: Input high at gate open adds one count.
// R16: Resets return pins to input; latch cleared only on power-on.
// R17: Halt keeps pin configuration unchanged.
// R18: Gate code 00=1ms, 01=4ms, 10=8ms, 11=open.
// R19: Function code 00 off, 01 FM shared, 10 AM pin, 11 AM shared.
// R20: Counter wraps from maximum to zero and continues.
// R21: Start and clear are self-clearing single-cycle strobes.
`include "ifcnt_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ifcnt_top #(
  parameter int unsigned CNT_W    = 16,
  parameter int unsigned TICK_DIV = `IFCNT_TICK_DIV
) (
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  input  wire logic                por_i,
  input  wire logic                ce_reset_i,
  input  wire logic                clock_stop_i,
  input  wire logic                halt_i,
  input  wire logic                mode_we_i,
  input  wire ifcnt_pkg::ifcnt_mode_t mode_i,
  input  wire ifcnt_pkg::ifcnt_cmd_t  cmd_i,
  input  wire logic                rd_i,
  input  wire logic [6:0]          addr_i,
  output logic [CNT_W-1:0]         transfer_buffer_o,
  output logic                     rd_hit_o,
  output logic                     gate_open_status_o,
  output ifcnt_pkg::ifcnt_mode_t   mode_o,
  input  wire logic                shared_pin_i,
  input  wire logic                am_pin_i,
  input  wire logic [1:0]          port_latch_we_i,
  input  wire logic [1:0]          port_latch_d_i,
  input  wire logic [1:0]          port_dir_out_i,
  output logic [1:0]               port_o,
  output logic [1:0]               port_oe_o,
  output logic [1:0]               port_in_o
);
  import ifcnt_pkg::*;

  ifcnt_mode_t          mode_r;
  logic                 cfg_rst;
  logic [2:0]           sh_sync_r;
  logic [2:0]           am_sync_r;
  logic                 sh_lvl_r;
  logic                 am_lvl_r;
  logic                 src_prev_r;
  logic                 div2_r;
  logic                 src_lvl;
  logic                 src_edge;
  logic [15:0]          tick_cnt_r;
  logic                 tick;
  logic                 armed_r;
  logic                 timed_open_r;
  logic [7:0]           ms_left_r;
  logic                 gate_open;
  logic [CNT_W-1:0]     count_r;
  logic [1:0]           latch_r;
  logic [1:0]           dir_r;
  logic                 src_prev_sh;

  function automatic logic [7:0] gate_ms(input ifcnt_gate_t g);
    unique case (g)
      IFCNT_GT_1MS: gate_ms = `IFCNT_GATE_1MS; // [R18]
      IFCNT_GT_4MS: gate_ms = `IFCNT_GATE_4MS; // [R18]
      IFCNT_GT_8MS: gate_ms = `IFCNT_GATE_8MS; // [R18]
      IFCNT_GT_OPEN: gate_ms = 8'h00;
    endcase
  endfunction

  // Any of the four resets clears mode; halt freezes it
  assign cfg_rst = srst_i | por_i | ce_reset_i | clock_stop_i; // [R16]

  always_ff @(posedge clk_i) begin
    if (cfg_rst) begin
      mode_r <= '0; // [R16]
    end else if (mode_we_i && !halt_i) begin // [R17]
      mode_r <= mode_i;
    end
  end
  assign mode_o = mode_r;

  // Pins are asynchronous; change taken once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sh_sync_r <= 3'h0;
      am_sync_r <= 3'h0;
      sh_lvl_r  <= 1'b0;
      am_lvl_r  <= 1'b0;
    end else begin
      sh_sync_r <= {sh_sync_r[1:0], shared_pin_i};
      am_sync_r <= {am_sync_r[1:0], am_pin_i};
      if (sh_sync_r[1] == sh_sync_r[2]) begin
        sh_lvl_r <= sh_sync_r[2];
      end
      if (am_sync_r[1] == am_sync_r[2]) begin
        am_lvl_r <= am_sync_r[2];
      end
    end
  end

  always_comb begin
    unique case (mode_r.func) // [R19]
      IFCNT_FN_OFF:       src_lvl = 1'b0;
      IFCNT_FN_FM_SHARED: src_lvl = div2_r; // [R10]
      IFCNT_FN_AM_AMPIN:  src_lvl = am_lvl_r; // [R11]
      IFCNT_FN_AM_SHARED: src_lvl = sh_lvl_r; // [R11]
    endcase
  end

  // Divide-by-two toggles on each rising edge of the shared pin
  always_ff @(posedge clk_i) begin
    if (srst_i || mode_r.func != IFCNT_FN_FM_SHARED) begin
      div2_r <= 1'b0;
    end else if (sh_lvl_r && !src_prev_sh) begin
      div2_r <= ~div2_r; // [R10]
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      src_prev_sh <= 1'b0;
    end else begin
      src_prev_sh <= sh_lvl_r;
    end
  end

  // Previous level is zero while gate shut, so a high input at open counts once
  always_ff @(posedge clk_i) begin
    if (srst_i || !gate_open) begin
      src_prev_r <= 1'b0; // [R15]
    end else begin
      src_prev_r <= src_lvl;
    end
  end
  assign src_edge = gate_open && src_lvl && !src_prev_r;

  // Millisecond tick divided from system clock
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tick_cnt_r <= 16'h0000;
    end else if (tick) begin
      tick_cnt_r <= 16'h0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001; // [R14]
    end
  end
  assign tick = (tick_cnt_r == 16'(TICK_DIV - 1)); // [R14]

  // Start strobe arms; next tick opens for the selected number of ticks
  always_ff @(posedge clk_i) begin
    if (cfg_rst || mode_r.gate == IFCNT_GT_OPEN) begin
      armed_r      <= 1'b0;
      timed_open_r <= 1'b0;
      ms_left_r    <= 8'h00;
    end else if (cmd_i.count_start_flag && !timed_open_r) begin
      armed_r <= 1'b1; // [R1] [R21]
    end else if (armed_r && tick) begin
      armed_r      <= 1'b0;
      timed_open_r <= 1'b1; // [R1]
      ms_left_r    <= gate_ms(mode_r.gate);
    end else if (timed_open_r && tick) begin
      if (ms_left_r == 8'h01) begin
        timed_open_r <= 1'b0; // [R1]
      end
      ms_left_r <= ms_left_r - 8'h01;
    end
  end

  assign gate_open = (mode_r.func != IFCNT_FN_OFF) &&
                     ((mode_r.gate == IFCNT_GT_OPEN) || timed_open_r); // [R5] [R8]
  // Status high from start write until close
  assign gate_open_status_o = armed_r || timed_open_r ||
                              (mode_r.gate == IFCNT_GT_OPEN); // [R3] [R4]

  // Clear strobe wins over a simultaneous edge
  always_ff @(posedge clk_i) begin
    if (srst_i || cmd_i.count_clear_flag) begin
      count_r <= '0; // [R7] [R21]
    end else if (src_edge) begin
      count_r <= count_r + 1'b1; // [R2] [R20]
    end
  end

  assign rd_hit_o = rd_i && (addr_i == `IFCNT_ADDR_RESULT);
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      transfer_buffer_o <= '0;
    end else if (rd_hit_o) begin
      transfer_buffer_o <= count_r; // [R9]
    end
  end

  // Port latch clears only at power-on; direction forced input by any reset
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      latch_r <= 2'b00; // [R16]
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (port_latch_we_i[i] && !halt_i) begin
          latch_r[i] <= port_latch_d_i[i];
        end
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (cfg_rst) begin
      dir_r <= 2'b00; // [R16]
    end else if (!halt_i) begin
      dir_r <= port_dir_out_i; // [R17]
    end
  end
  assign port_o    = latch_r;
  assign port_oe_o = (mode_r.func == IFCNT_FN_OFF) ? dir_r : 2'b00;
  assign port_in_o = {sh_lvl_r, am_lvl_r};

  chk_start_sets_status: assert property (@(posedge clk_i) disable iff (srst_i)
    (cmd_i.count_start_flag && !cfg_rst && mode_r.gate != IFCNT_GT_OPEN)
      |=> gate_open_status_o) else $error("status not set by start"); // [R4]
  chk_close_clears_status: assert property (@(posedge clk_i) disable iff (srst_i)
    ($fell(timed_open_r) && mode_r.gate != IFCNT_GT_OPEN && !armed_r)
      |-> !gate_open_status_o) else $error("status not cleared"); // [R3]
  chk_open_gate_immediate: assert property (@(posedge clk_i) disable iff (srst_i)
    (mode_r.gate == IFCNT_GT_OPEN && mode_r.func != IFCNT_FN_OFF) |-> gate_open)
    else $error("open gate not open"); // [R5]
  chk_opens_on_tick: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(timed_open_r) |-> $past(tick) && $past(armed_r)) else $error("gate opened off tick"); // [R1]
  chk_clear_count: assert property (@(posedge clk_i) disable iff (srst_i)
    cmd_i.count_clear_flag |=> count_r == '0) else $error("clear ignored"); // [R7]
  chk_count_step: assert property (@(posedge clk_i) disable iff (srst_i)
    (!cmd_i.count_clear_flag && src_edge) |=> count_r == $past(count_r) + 1'b1)
    else $error("count step wrong"); // [R2]
  chk_count_hold: assert property (@(posedge clk_i) disable iff (srst_i)
    (!cmd_i.count_clear_flag && !gate_open) |=> count_r == $past(count_r))
    else $error("count moved with gate shut"); // [R2]
  chk_read_result: assert property (@(posedge clk_i) disable iff (srst_i)
    rd_hit_o |=> transfer_buffer_o == $past(count_r)) else $error("read wrong"); // [R9]
  chk_tick_period: assert property (@(posedge clk_i) disable iff (srst_i)
    tick |=> !tick) else $error("tick too frequent"); // [R14]
  chk_reset_pins_input: assert property (@(posedge clk_i)
    cfg_rst |=> port_oe_o == 2'b00) else $error("pins not input after reset"); // [R16]

  // Timed gate sequencing
  chk_gate_length: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(timed_open_r) |-> ms_left_r == gate_ms(mode_r.gate))
    else $error("gate length code wrong"); // [R18]
  chk_close_on_last: assert property (@(posedge clk_i) disable iff (srst_i)
    (timed_open_r && tick && ms_left_r == 8'h01 && mode_r.gate != IFCNT_GT_OPEN)
      |=> !timed_open_r) else $error("gate not closed at end"); // [R1]
  chk_timed_countdown: assert property (@(posedge clk_i) disable iff (srst_i)
    (timed_open_r && tick && ms_left_r != 8'h01 && !cfg_rst && mode_r.gate != IFCNT_GT_OPEN)
      |=> timed_open_r && ms_left_r == $past(ms_left_r) - 8'h01) else $error("bad countdown"); // [R1]
  chk_armed_waits_tick: assert property (@(posedge clk_i) disable iff (srst_i)
    (armed_r && !tick && !cfg_rst && mode_r.gate != IFCNT_GT_OPEN) |=> armed_r)
    else $error("arm lost before tick"); // [R1]
  chk_status_armed: assert property (@(posedge clk_i) disable iff (srst_i)
    armed_r |-> gate_open_status_o) else $error("status low while armed"); // [R4]
  chk_start_ignored_open: assert property (@(posedge clk_i) disable iff (srst_i)
    (mode_r.gate == IFCNT_GT_OPEN) |=> !armed_r) else $error("start taken in open setting"); // [R5]
  chk_leave_open_closes: assert property (@(posedge clk_i) disable iff (srst_i)
    (mode_r.gate != IFCNT_GT_OPEN && !timed_open_r) |-> !gate_open)
    else $error("gate open without timer"); // [R8]

  // Input selection and counting
  chk_off_no_count: assert property (@(posedge clk_i) disable iff (srst_i)
    (mode_r.func == IFCNT_FN_OFF) |-> !src_edge) else $error("count in off mode"); // [R19]
  chk_fm_divides: assert property (@(posedge clk_i) disable iff (srst_i)
    (mode_r.func == IFCNT_FN_FM_SHARED && sh_lvl_r && !src_prev_sh)
      |=> div2_r != $past(div2_r)) else $error("divider missed edge"); // [R10]
  chk_fm_div_idle: assert property (@(posedge clk_i) disable iff (srst_i)
    (mode_r.func != IFCNT_FN_FM_SHARED) |=> !div2_r) else $error("divider not idle"); // [R10]
  chk_am_pin_direct: assert property (@(posedge clk_i) disable iff (srst_i)
    (mode_r.func == IFCNT_FN_AM_AMPIN) |-> src_lvl == am_lvl_r)
    else $error("am pin not routed"); // [R11]
  chk_am_shared_direct: assert property (@(posedge clk_i) disable iff (srst_i)
    (mode_r.func == IFCNT_FN_AM_SHARED) |-> src_lvl == sh_lvl_r)
    else $error("shared pin not routed"); // [R11]
  chk_edge_at_open: assert property (@(posedge clk_i) disable iff (srst_i)
    ($rose(gate_open) && src_lvl) |-> src_edge) else $error("high input at open missed"); // [R15]
  chk_count_wrap: assert property (@(posedge clk_i) disable iff (srst_i)
    (src_edge && !cmd_i.count_clear_flag && count_r == '1) |=> count_r == '0)
    else $error("count did not wrap"); // [R20]

  // Reset and halt
  chk_reset_mode: assert property (@(posedge clk_i) disable iff (srst_i)
    cfg_rst |=> mode_r == '0) else $error("mode kept over reset"); // [R16]
  chk_halt_holds_mode: assert property (@(posedge clk_i) disable iff (srst_i)
    (halt_i && !cfg_rst) |=> mode_r == $past(mode_r)) else $error("mode moved in halt"); // [R17]
endmodule
`default_nettype wire

// [common/ifcnt_defs.svh]
// Constants for the gated intermediate-frequency counter
`ifndef IFCNT_DEFS_SVH
`define IFCNT_DEFS_SVH
`define IFCNT_ADDR_RESULT   7'h43
`define IFCNT_CLK_HZ        75000
`define IFCNT_TICK_HZ       1000
`define IFCNT_TICK_DIV      (`IFCNT_CLK_HZ / `IFCNT_TICK_HZ)
`define IFCNT_GATE_1MS      8'd1
`define IFCNT_GATE_4MS      8'd4
`define IFCNT_GATE_8MS      8'd8
`define IFCNT_SYNC_STAGES   3
`endif

// [common/ifcnt_pkg.sv]
// Types for the gated intermediate-frequency counter
package ifcnt_pkg;
  typedef enum logic [1:0] {
    IFCNT_GT_1MS,
    IFCNT_GT_4MS,
    IFCNT_GT_8MS,
    IFCNT_GT_OPEN
  } ifcnt_gate_t;
  typedef enum logic [1:0] {
    IFCNT_FN_OFF,
    IFCNT_FN_FM_SHARED,
    IFCNT_FN_AM_AMPIN,
    IFCNT_FN_AM_SHARED
  } ifcnt_func_t;
  typedef struct packed {
    ifcnt_func_t func;
    ifcnt_gate_t gate;
  } ifcnt_mode_t;
  typedef struct packed {
    logic count_start_flag;
    logic count_clear_flag;
  } ifcnt_cmd_t;
endpackage

// [bench/ifcnt_src.sv]
// Tuner IF source model driving both counter input pins
`timescale 1ns/1ps
`default_nettype none
module ifcnt_src (
  input  wire logic clk_i,
  input  wire logic en_i,
  output logic      shared_o,
  output logic      am_o
);
  logic [4:0] ph_r;
  // Shared pin period 5 clocks, AM pin period 20; both held low when off
  always_ff @(posedge clk_i) begin
    ph_r     <= (ph_r == 5'h13 || !en_i) ? 5'h00 : ph_r + 5'h01;
    shared_o <= en_i && (ph_r % 5 < 2);
    am_o     <= en_i && (ph_r < 5'h0a);
  end
endmodule
`default_nettype wire

// [bench/tb_if_frequency_counter.sv]
// Self-checking bench for the gated IF counter
`timescale 1ns/1ps
`default_nettype none
module tb_if_frequency_counter;
  import ifcnt_pkg::*;
  localparam int TD = 5;
  logic        clk, srst, por, ce, cstop, halt, mode_we, rd, en, hit_d, hit, stat, sh, am;
  logic [6:0]  addr;
  logic [1:0]  pl_we, pl_d, pdir, pout, poe, pin;
  logic [15:0] dbuf;
  logic [17:0] q[$];
  logic [17:0] e;
  ifcnt_mode_t mode, mode_rb;
  ifcnt_cmd_t  cmd;
  int          n_mismatch, cmp_count, n, ln, pd;

  ifcnt_top #(.TICK_DIV(TD)) u_dut (
    .clk_i(clk), .srst_i(srst), .por_i(por), .ce_reset_i(ce), .clock_stop_i(cstop),
    .halt_i(halt), .mode_we_i(mode_we), .mode_i(mode), .cmd_i(cmd), .rd_i(rd),
    .addr_i(addr), .transfer_buffer_o(dbuf), .rd_hit_o(hit), .gate_open_status_o(stat),
    .mode_o(mode_rb), .shared_pin_i(sh), .am_pin_i(am), .port_latch_we_i(pl_we),
    .port_latch_d_i(pl_d), .port_dir_out_i(pdir), .port_o(pout), .port_oe_o(poe),
    .port_in_o(pin)
  );
  ifcnt_src u_src (.clk_i(clk), .en_i(en), .shared_o(sh), .am_o(am));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    cmp_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic setm(input ifcnt_func_t f, input ifcnt_gate_t g);
    @(posedge clk);
    mode_we <= 1'b1;
    mode    <= '{func: f, gate: g};
    @(posedge clk);
    mode_we <= 1'b0;
  endtask

  task automatic strobe(input ifcnt_cmd_t c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= '0;
  endtask

  // Expected note is {slack, lowest count}; slack covers the +1 edge error
  task automatic rd_op(input logic [6:0] a, input logic [17:0] x);
    if (a == 7'h43) q.push_back(x);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    #1 chk(16'(hit), 16'(a == 7'h43));
    @(posedge clk);
    rd <= 1'b0;
    cyc(2);
  endtask

  // Buffer is valid one edge after the read hit
  always @(posedge clk) begin
    hit_d <= hit;
    if (hit_d && q.size() > 0) begin
      e = q.pop_front();
      cmp_count++;
      if (((dbuf - e[15:0]) <= {14'h0, e[17:16]}) !== 1'b1) begin
        n_mismatch++;
        $display("[ERR] %0t got %h exp %h", $time, dbuf, e[15:0]);
      end
    end
  end

  initial begin
    #50us;
    n_mismatch++;
    test_done();
  end

  initial begin
    {srst, por, ce, halt, mode_we, rd, en} = 7'h40;
    {pl_we, pl_d, pdir} = '0;
    cstop = 1'b0;
    addr = '0;
    mode = '0;
    cmd = '0;
    n_mismatch = 0;
    cmp_count = 0;
    void'($urandom(75));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    en   <= 1'b1;
    for (int g = 0; g < 3; g++) begin
      for (int f = 1; f < 4; f++) begin
        ln = TD * ((g == 0) ? 1 : 4 * g);
        pd = (f == 1) ? 10 : (f == 2) ? 20 : 5;
        setm(ifcnt_func_t'(f), ifcnt_gate_t'(g));
        cyc(10);
        strobe(2'b01);
        strobe(2'b10);
        #1 chk(16'(stat), 16'h1);
        n = 0;
        while (stat === 1'b1 && n < 400) begin
          @(posedge clk);
          #1 n++;
        end
        chk(16'(n >= ln && n <= ln + TD + 3), 16'h1);
        rd_op(7'h43, {(ln % pd == 0) ? 2'd1 : 2'd2, 16'(ln / pd)});
      end
    end
    rd_op(7'($urandom_range(66, 0)), '0);
    setm(IFCNT_FN_AM_SHARED, IFCNT_GT_OPEN);
    cyc(2);
    #1 chk(16'(stat), 16'h1);
    strobe(2'b01);
    cyc(50);
    setm(IFCNT_FN_AM_SHARED, IFCNT_GT_1MS);
    #1 chk(16'(stat), 16'h0);
    rd_op(7'h43, {2'd2, 16'h0009});
    setm(IFCNT_FN_AM_SHARED, IFCNT_GT_OPEN);
    cyc(20);
    strobe(2'b01);
    setm(IFCNT_FN_AM_SHARED, IFCNT_GT_1MS);
    rd_op(7'h43, {2'd1, 16'h0000});
    setm(IFCNT_FN_OFF, IFCNT_GT_1MS);
    pl_d  <= 2'($urandom);
    pl_we <= 2'b11;
    pdir  <= 2'b11;
    @(posedge clk);
    pl_we <= 2'b00;
    #1 chk(16'(poe), 16'h3);
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    ce <= 1'b0;
    #1 chk(16'(poe), 16'h0);
    @(posedge clk);
    #1 chk(16'(pout), 16'(pl_d));
    chk(16'(mode_rb), 16'h0);
    @(posedge clk);
    cstop <= 1'b1;
    @(posedge clk);
    cstop <= 1'b0;
    #1 chk(16'(poe), 16'h0);
    chk(16'(pout), 16'(pl_d));
    @(posedge clk);
    halt <= 1'b1;
    setm(IFCNT_FN_FM_SHARED, IFCNT_GT_8MS);
    #1 chk(16'(mode_rb), 16'h0);
    @(posedge clk);
    halt <= 1'b0;
    por  <= 1'b1;
    @(posedge clk);
    por <= 1'b0;
    @(posedge clk);
    #1 chk(16'(pout), 16'h0);
    @(posedge clk);
    en <= 1'b0;
    cyc(8);
    #1 chk(16'(pin), 16'h0);
    test_done();
  end
endmodule
`default_nettype wire
